// ===== hw/bus_fabric_pkg.sv
package bus_fabric_pkg;
   // Address map bases and limits
   localparam logic [31:0] FLASH_BASE      = 32'h0000_0000;
   localparam logic [31:0] FLASH_LAST      = 32'h1fff_ffff;
   localparam logic [31:0] SRAM_BASE       = 32'h2000_0000;
   localparam logic [31:0] SRAM_LAST       = 32'h3fff_ffff;
   localparam logic [31:0] APB_BASE        = 32'h4000_0000;
   localparam logic [31:0] APB_LAST        = 32'h4007_ffff;
   localparam logic [31:0] AHBP_BASE       = 32'h4008_0000;
   localparam logic [31:0] AHBP_LAST       = 32'h400f_ffff;
   localparam logic [31:0] FLASHCTL_BASE   = 32'h4008_0000;
   localparam logic [31:0] FLASHCTL_LAST   = 32'h4008_1fff;
   localparam logic [31:0] CLKRST_BASE     = 32'h4008_8000;
   localparam logic [31:0] CLKRST_LAST     = 32'h4008_9fff;
   // Flash geometry and SRAM size
   localparam int          FLASH_PAGES     = 32;
   localparam int          FLASH_PAGE_BYTES = 1024;
   localparam int          SRAM_BYTES      = 4096;
   // APB peripheral slots, 4 KB each
   localparam int          APB_SLOTS       = 128;
   localparam int          APB_SLOT_LSB    = 12;
   // AHB transfer encodings
   localparam logic [1:0]  HTRANS_IDLE     = 2'b00;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
   localparam logic [2:0]  HSIZE_BYTE      = 3'b000;
   localparam logic [2:0]  HSIZE_HALF      = 3'b001;
   localparam logic [2:0]  HSIZE_WORD      = 3'b010;
   // Slave select one-hot codes
   localparam logic [4:0]  SEL_NONE        = 5'h00;
   localparam logic [4:0]  SEL_FLASH       = 5'h01;
   localparam logic [4:0]  SEL_SRAM        = 5'h02;
   localparam logic [4:0]  SEL_AHBP        = 5'h04;
   localparam logic [4:0]  SEL_APB         = 5'h08;
   localparam logic [4:0]  SEL_ERR         = 5'h10;
endpackage

// ===== hw/apb_bridge.sv
module apb_bridge
   import bus_fabric_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic        start_in,
   input  wire logic        write_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [2:0]  size_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic [31:0] prdata_in,
   input  wire logic        pready_in,
   output logic             busy_out,
   output logic             done_out,
   output logic [31:0]      rdata_out,
   output logic             psel_out,
   output logic             penable_out,
   output logic             pwrite_out,
   output logic [31:0]      paddr_out,
   output logic [31:0]      pwdata_out
);
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SETUP  = 3'b010,
      ST_ACCESS = 3'b100
   } apb_state_e;
   apb_state_e state;
   logic [31:0] next_wdata;
   logic        xfer_end;

   // Narrow write data copied onto every byte lane
   assign next_wdata = (size_in == HSIZE_BYTE) ? {4{hwdata_in[8*addr_in[1:0] +: 8]}} :
                       (size_in == HSIZE_HALF) ? {2{hwdata_in[16*addr_in[1] +: 16]}} :
                       hwdata_in;
   assign xfer_end   = (state == ST_ACCESS) && pready_in;

   // Setup then access phase, held until the slave is ready
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state       <= ST_IDLE;
         psel_out    <= 1'b0;
         penable_out <= 1'b0;
         pwrite_out  <= 1'b0;
         paddr_out   <= 32'h0000_0000;
         pwdata_out  <= 32'h0000_0000;
         busy_out    <= 1'b0;
         done_out    <= 1'b0;
         rdata_out   <= 32'h0000_0000;
      end else begin
         done_out <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (start_in) begin
                  state      <= ST_SETUP;
                  psel_out   <= 1'b1;
                  pwrite_out <= write_in;
                  paddr_out  <= addr_in;
                  busy_out   <= 1'b1;
               end
            end
            ST_SETUP: begin
               state       <= ST_ACCESS;
               penable_out <= 1'b1;
               pwdata_out  <= next_wdata;
            end
            ST_ACCESS: begin
               if (xfer_end) begin
                  state       <= ST_IDLE;
                  psel_out    <= 1'b0;
                  penable_out <= 1'b0;
                  busy_out    <= 1'b0;
                  done_out    <= 1'b1;
                  rdata_out   <= prdata_in;
               end
            end
         endcase
      end
   end

   a_access_follows_setup: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (psel_out && !penable_out) |=> penable_out) else $error("access phase missing");
   a_done_after_ready: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (penable_out && pready_in) |=> (done_out && !psel_out))
      else $error("apb completion missed");
endmodule

// ===== hw/system_bus_address_decoder.sv
module system_bus_address_decoder
   import bus_fabric_pkg::*;
#(
   parameter int FLASH_PAGE_COUNT = FLASH_PAGES
)(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // Processor request
   input  wire logic [1:0]  cpu_htrans_in,
   input  wire logic [31:0] cpu_haddr_in,
   input  wire logic        cpu_hwrite_in,
   input  wire logic [2:0]  cpu_hsize_in,
   // Debug request
   input  wire logic [1:0]  dbg_htrans_in,
   input  wire logic [31:0] dbg_haddr_in,
   input  wire logic        dbg_hwrite_in,
   input  wire logic [2:0]  dbg_hsize_in,
   input  wire logic [31:0] hwdata_in,
   // Clock gates from the clock control block
   input  wire logic [APB_SLOTS-1:0] apb_clock_gate_reg_in,
   // Slave read data
   input  wire logic [31:0] flash_rdata_in,
   input  wire logic [31:0] sram_rdata_in,
   input  wire logic [31:0] ahbp_rdata_in,
   input  wire logic [31:0] prdata_in,
   input  wire logic        pready_in,
   // Shared answer to the masters
   output logic             hready_out,
   output logic             hresp_out,
   output logic [31:0]      hrdata_out,
   output logic             cpu_grant_out,
   output logic             dbg_grant_out,
   // Flash read port
   output logic             flash_re_out,
   output logic [31:0]      flash_addr_out,
   // SRAM port
   output logic             sram_en_out,
   output logic             sram_we_out,
   output logic [3:0]       sram_be_out,
   output logic [31:0]      sram_addr_out,
   output logic [31:0]      sram_wdata_out,
   // AHB peripheral register bus
   output logic             flash_controller_sel_out,
   output logic             clock_reset_unit_sel_out,
   output logic             ahbp_we_out,
   output logic [31:0]      ahbp_addr_out,
   output logic [31:0]      ahbp_wdata_out,
   output logic             ahbp_clk_en_out,
   // APB side
   output logic             psel_out,
   output logic             penable_out,
   output logic             pwrite_out,
   output logic [31:0]      paddr_out,
   output logic [31:0]      pwdata_out,
   output logic [APB_SLOTS-1:0] apb_clk_en_out
);
   // Refuse a flash size the decoder cannot map
   if (FLASH_PAGE_COUNT < 1 || FLASH_PAGE_COUNT > FLASH_PAGES) begin : g_bad_pages
      $error("flash page count out of range");
   end

   localparam logic [31:0] FLASH_BYTES = 32'(FLASH_PAGE_COUNT * FLASH_PAGE_BYTES);

   // Arbitration: processor first, debug waits
   logic        cpu_req;
   logic        dbg_req;
   logic        use_cpu;
   logic [31:0] sel_addr;
   logic        sel_write;
   logic [2:0]  sel_size;
   logic        sel_valid;
   assign cpu_req   = cpu_htrans_in[1];
   assign dbg_req   = dbg_htrans_in[1];
   assign use_cpu   = cpu_req;
   assign sel_valid = cpu_req || dbg_req;
   assign sel_addr  = use_cpu ? cpu_haddr_in  : dbg_haddr_in;
   assign sel_write = use_cpu ? cpu_hwrite_in : dbg_hwrite_in;
   assign sel_size  = use_cpu ? cpu_hsize_in  : dbg_hsize_in;

   // Region decode over the full 32-bit space
   logic in_flash;
   logic in_sram;
   logic in_apb;
   logic in_flashctl;
   logic in_clkrst;
   logic size_ok;
   logic [4:0] dec_sel;
   assign in_flash    = (sel_addr <= FLASH_LAST) && (sel_addr - FLASH_BASE < FLASH_BYTES);
   assign in_sram     = (sel_addr >= SRAM_BASE) && (sel_addr - SRAM_BASE < 32'(SRAM_BYTES));
   assign in_apb      = (sel_addr >= APB_BASE) && (sel_addr <= APB_LAST);
   assign in_flashctl = (sel_addr >= FLASHCTL_BASE) && (sel_addr <= FLASHCTL_LAST);
   assign in_clkrst   = (sel_addr >= CLKRST_BASE) && (sel_addr <= CLKRST_LAST);
   assign size_ok     = (sel_size == HSIZE_BYTE) || (sel_size == HSIZE_HALF) ||
                        (sel_size == HSIZE_WORD);
   // Flash write, narrow AHB peripheral access, or unmapped all give error
   assign dec_sel = !size_ok                               ? SEL_ERR :
                    (in_flash && !sel_write)               ? SEL_FLASH :
                    in_flash                               ? SEL_ERR :
                    in_sram                                ? SEL_SRAM :
                    in_apb                                 ? SEL_APB :
                    ((in_flashctl || in_clkrst) && sel_size == HSIZE_WORD) ? SEL_AHBP :
                    SEL_ERR;

   // SRAM byte enables from size and address
   logic [3:0] next_be;
   assign next_be = (sel_size == HSIZE_BYTE) ? 4'(4'h1 << sel_addr[1:0]) :
                    (sel_size == HSIZE_HALF) ? (sel_addr[1] ? 4'hc : 4'h3) : 4'hf;

   // Data phase tracking
   logic [4:0]  dphase;
   logic        dphase_write;
   logic [31:0] dphase_addr;
   logic [3:0]  dphase_be;
   logic        err_second;
   logic        bridge_busy;
   logic        bridge_done;
   logic [31:0] bridge_rdata;
   logic        bridge_start;
   logic        take;
   logic        next_ready;
   assign next_ready   = (dphase == SEL_APB) ? bridge_done :
                         (dphase == SEL_ERR) ? err_second : 1'b1;
   assign take         = sel_valid && next_ready;
   assign bridge_start = take && (dec_sel == SEL_APB);

   // Address phase capture
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dphase       <= SEL_NONE;
         dphase_write <= 1'b0;
         dphase_addr  <= 32'h0000_0000;
         dphase_be    <= 4'h0;
      end else if (next_ready) begin
         dphase       <= take ? dec_sel : SEL_NONE;
         dphase_write <= sel_write;
         dphase_addr  <= sel_addr;
         dphase_be    <= next_be;
      end
   end

   // Two-cycle error response: first hresp with low ready, then ready
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         err_second <= 1'b0;
      end else begin
         err_second <= (dphase == SEL_ERR) && !err_second;
      end
   end

   // Answer to master
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hready_out    <= 1'b1;
         hresp_out     <= 1'b0;
         hrdata_out    <= 32'h0000_0000;
         cpu_grant_out <= 1'b0;
         dbg_grant_out <= 1'b0;
      end else begin
         hready_out    <= take ? (dec_sel != SEL_APB && dec_sel != SEL_ERR) :
                          (next_ready || dphase == SEL_ERR);
         hresp_out     <= take ? (dec_sel == SEL_ERR) : (dphase == SEL_ERR && !err_second);
         cpu_grant_out <= take && use_cpu;
         dbg_grant_out <= take && !use_cpu;
         hrdata_out    <= (dphase == SEL_FLASH) ? flash_rdata_in :
                          (dphase == SEL_SRAM)  ? sram_rdata_in :
                          (dphase == SEL_AHBP)  ? ahbp_rdata_in :
                          (dphase == SEL_APB && bridge_done) ? bridge_rdata : 32'h0000_0000;
      end
   end

   // Flash and SRAM strobes; the flash port is read only
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flash_re_out   <= 1'b0;
         flash_addr_out <= 32'h0000_0000;
         sram_en_out    <= 1'b0;
         sram_we_out    <= 1'b0;
         sram_be_out    <= 4'h0;
         sram_addr_out  <= 32'h0000_0000;
         sram_wdata_out <= 32'h0000_0000;
      end else begin
         flash_re_out   <= take && (dec_sel == SEL_FLASH);
         flash_addr_out <= {sel_addr[31:2], 2'b00};
         sram_en_out    <= (take && dec_sel == SEL_SRAM) || (dphase == SEL_SRAM && dphase_write);
         sram_we_out    <= (dphase == SEL_SRAM) && dphase_write;
         sram_be_out    <= (dphase == SEL_SRAM) ? dphase_be : next_be;
         sram_addr_out  <= (dphase == SEL_SRAM && dphase_write) ? dphase_addr : sel_addr;
         sram_wdata_out <= hwdata_in;
      end
   end

   // AHB peripheral register bus, clock always on after reset
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flash_controller_sel_out <= 1'b0;
         clock_reset_unit_sel_out <= 1'b0;
         ahbp_we_out              <= 1'b0;
         ahbp_addr_out            <= 32'h0000_0000;
         ahbp_wdata_out           <= 32'h0000_0000;
         ahbp_clk_en_out          <= 1'b1;
      end else begin
         flash_controller_sel_out <= take && dec_sel == SEL_AHBP && in_flashctl;
         clock_reset_unit_sel_out <= take && dec_sel == SEL_AHBP && in_clkrst;
         ahbp_we_out              <= (dphase == SEL_AHBP) && dphase_write;
         ahbp_addr_out            <= (dphase == SEL_AHBP) ? dphase_addr : sel_addr;
         ahbp_wdata_out           <= hwdata_in;
         ahbp_clk_en_out          <= 1'b1;
      end
   end

   // Per-slot APB clock gates, off from reset
   genvar g;
   generate
      for (g = 0; g < APB_SLOTS; g++) begin : g_apb_clk
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               apb_clk_en_out[g] <= 1'b0;
            end else begin
               apb_clk_en_out[g] <= apb_clock_gate_reg_in[g];
            end
         end
      end
   endgenerate

   // Bridge control copies of the request
   logic [31:0] br_addr;
   logic        br_write;
   logic [2:0]  br_size;
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         br_addr  <= 32'h0000_0000;
         br_write <= 1'b0;
         br_size  <= HSIZE_WORD;
      end else if (bridge_start) begin
         br_addr  <= sel_addr;
         br_write <= sel_write;
         br_size  <= sel_size;
      end
   end
   logic br_go;
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         br_go <= 1'b0;
      end else begin
         br_go <= bridge_start;
      end
   end

   apb_bridge apb_bridge_inst (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .start_in    (br_go),
      .write_in    (br_write),
      .addr_in     (br_addr),
      .size_in     (br_size),
      .hwdata_in   (hwdata_in),
      .prdata_in   (prdata_in),
      .pready_in   (pready_in),
      .busy_out    (bridge_busy),
      .done_out    (bridge_done),
      .rdata_out   (bridge_rdata),
      .psel_out    (psel_out),
      .penable_out (penable_out),
      .pwrite_out  (pwrite_out),
      .paddr_out   (paddr_out),
      .pwdata_out  (pwdata_out)
   );

   a_cpu_beats_debug: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (cpu_req && dbg_req && next_ready) |=> (cpu_grant_out && !dbg_grant_out))
      else $error("debug granted over processor");
   a_flash_write_err: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (take && in_flash && sel_write) |=> (hresp_out && !hready_out) ##1 (hresp_out && hready_out))
      else $error("flash write not errored");
   a_flash_no_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      flash_re_out |-> !$past(sel_write)) else $error("flash strobed on write");
   a_unmapped_err: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (take && dec_sel == SEL_ERR) |=> hresp_out) else $error("unmapped not errored");
   a_ahbp_word_only: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (flash_controller_sel_out || clock_reset_unit_sel_out) |-> $past(sel_size) == HSIZE_WORD)
      else $error("narrow ahb peripheral access");
   a_ahbp_clk_on: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      ahbp_clk_en_out) else $error("ahb peripheral clock off");
   a_apb_clk_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      apb_clk_en_out == $past(apb_clock_gate_reg_in)) else $error("apb gate mismatch");
   a_apb_ready_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (bridge_start) |=> !hready_out ##1 (!hready_out && psel_out))
      else $error("ready not held during apb");
   a_sram_byte_be: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (take && dec_sel == SEL_SRAM && sel_size == HSIZE_BYTE && !sel_write)
      |=> $onehot(sram_be_out)) else $error("sram byte lane wrong");
   a_busy_holds_ready: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      bridge_busy |-> !hready_out) else $error("ready high during apb");
endmodule

// ===== verif/apb_periph_model.sv
module apb_periph_model (
   input  wire logic        clk_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  wait_in,
   output logic             pready_out,
   output logic [31:0]      prdata_out,
   output logic [31:0]      wdata_seen_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] wait_cnt;
   logic       active;

   // Access phase stretched by wait_in cycles
   assign active     = psel_in && penable_in;
   assign pready_out = active && (wait_cnt >= wait_in);
   // Read data only while answering, a changing pattern otherwise
   assign prdata_out = (pready_out && !pwrite_in) ? (32'hc0de_0000 | {16'h0, paddr_in[15:0]})
                                                  : (~paddr_in ^ {28'h0, wait_cnt});

   // Wait counter and capture of the written word
   always_ff @(posedge clk_in) begin
      if (!active) wait_cnt <= 4'h0;
      else if (wait_cnt != 4'hf) wait_cnt <= wait_cnt + 4'h1;
      if (pready_out && pwrite_in) wdata_seen_out <= pwdata_in;
   end
endmodule

// ===== verif/test_system_bus_address_decoder.sv
module test_system_bus_address_decoder;
   import bus_fabric_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] FL_DATA = 32'h1357_9bdf;
   localparam logic [31:0] SR_DATA = 32'h2468_ace0;
   localparam logic [31:0] AP_DATA = 32'h0f1e_2d3c;

   logic                 sys_clk, rst, c_wr, d_wr, pready, err;
   logic [1:0]           c_trans, d_trans;
   logic [31:0]          c_addr, d_addr, hwdata, prdata, rd, wd_seen;
   logic [2:0]           c_size, d_size;
   logic [APB_SLOTS-1:0] gates, apb_clk_en;
   logic                 hready, hresp, cpu_g, dbg_g, flash_re, sram_en, sram_we, fc_sel, cr_sel;
   logic                 ahbp_we, ahbp_clk_en, psel, penable, pwrite;
   logic [31:0]          hrdata, flash_addr, sram_addr, sram_wdata, ahbp_addr, ahbp_wdata;
   logic [31:0]          paddr, pwdata, l_faddr, l_wd, l_sa;
   logic [3:0]           sram_be, l_be, pwait;
   int                   fails, cmp_count, cyc, n_flash, n_sramw, n_fc, n_cr;
   logic                 cpu_seen, dbg_seen;

   system_bus_address_decoder #(.FLASH_PAGE_COUNT(FLASH_PAGES)) system_bus_address_decoder_inst (
      .sys_clk_in(sys_clk), .rst_in(rst),
      .cpu_htrans_in(c_trans), .cpu_haddr_in(c_addr), .cpu_hwrite_in(c_wr), .cpu_hsize_in(c_size),
      .dbg_htrans_in(d_trans), .dbg_haddr_in(d_addr), .dbg_hwrite_in(d_wr), .dbg_hsize_in(d_size),
      .hwdata_in(hwdata), .apb_clock_gate_reg_in(gates), .flash_rdata_in(FL_DATA),
      .sram_rdata_in(SR_DATA), .ahbp_rdata_in(AP_DATA), .prdata_in(prdata), .pready_in(pready),
      .hready_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .cpu_grant_out(cpu_g),
      .dbg_grant_out(dbg_g), .flash_re_out(flash_re), .flash_addr_out(flash_addr),
      .sram_en_out(sram_en), .sram_we_out(sram_we), .sram_be_out(sram_be),
      .sram_addr_out(sram_addr), .sram_wdata_out(sram_wdata),
      .flash_controller_sel_out(fc_sel), .clock_reset_unit_sel_out(cr_sel),
      .ahbp_we_out(ahbp_we), .ahbp_addr_out(ahbp_addr), .ahbp_wdata_out(ahbp_wdata),
      .ahbp_clk_en_out(ahbp_clk_en), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
      .paddr_out(paddr), .pwdata_out(pwdata), .apb_clk_en_out(apb_clk_en));

   apb_periph_model apb_periph_model_inst (
      .clk_in(sys_clk), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .wait_in(pwait), .pready_out(pready),
      .prdata_out(prdata), .wdata_seen_out(wd_seen));

   // Clock source
   always #2.5 sys_clk = ~sys_clk;

   // Strobe counters and last values seen on the slave ports
   always @(posedge sys_clk) begin
      if (flash_re === 1'b1) begin
         n_flash++;
         l_faddr = flash_addr;
      end
      if (sram_we === 1'b1) begin
         n_sramw++;
         l_be = sram_be;
         l_wd = sram_wdata;
         l_sa = sram_addr;
      end
      if (fc_sel === 1'b1) n_fc++;
      if (cr_sel === 1'b1) n_cr++;
      if (cpu_g === 1'b1) cpu_seen = 1'b1;
      if (dbg_g === 1'b1) dbg_seen = 1'b1;
   end

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One processor transfer: request held for one clock, then wait for the answer
   task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz,
                       input logic [31:0] wd);
      c_trans = HTRANS_NONSEQ;
      c_addr  = a;
      c_wr    = w;
      c_size  = sz;
      @(posedge sys_clk);
      #1;
      c_trans = HTRANS_IDLE;
      hwdata  = wd;
      err     = (hresp === 1'b1);
      cyc     = (hready !== 1'b1) ? 1 : 0;
      do begin
         @(posedge sys_clk);
         #1;
         cyc++;
         if (hresp === 1'b1) err = 1'b1;
      end while (hready !== 1'b1 && cyc < 40);
      if (cyc >= 40) fails++;
      rd = hrdata;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task automatic t_reset();
      check("hready_idle", hready, 1'b1);
      check("ahbp_clk_en", ahbp_clk_en, 1'b1);
      check("apb_clk_en_rst", apb_clk_en, '0);
      gates = 128'h12;
      repeat (2) @(posedge sys_clk);
      #1;
      check("apb_clk_en_set", apb_clk_en, 128'h12);
   endtask

   task automatic t_flash();
      logic [31:0] a [3] = '{32'h0000_7ffd, 32'h0000_7ffe, 32'h0000_7ffc};
      int          n0;
      for (int i = 0; i < 3; i++) begin
         n0 = n_flash;
         xfer(a[i], 1'b0, 3'(i), 32'h0);
         check("flash_rd_err", err, 1'b0);
         check("flash_rd_data", rd, FL_DATA);
         check("flash_rd_cycles", cyc, 1);
         check("flash_re_count", n_flash - n0, 1);
         check("flash_addr", l_faddr, {a[i][31:2], 2'b00});
      end
      n0 = n_flash;
      xfer(32'h0000_0400, 1'b1, HSIZE_WORD, 32'h0);
      check("flash_wr_err", err, 1'b1);
      check("flash_wr_cycles", cyc, 2);
      check("flash_wr_no_strobe", n_flash - n0, 0);
   endtask

   task automatic t_sram();
      xfer(32'h2000_0ffd, 1'b1, HSIZE_BYTE, 32'h0000_a500);
      check("sram_byte_be", l_be, 4'b0010);
      check("sram_byte_data", l_wd[15:8], 8'ha5);
      check("sram_byte_addr", l_sa, 32'h2000_0ffd);
      xfer(32'h2000_0002, 1'b1, HSIZE_HALF, 32'hbeef_0000);
      check("sram_half_be", l_be, 4'b1100);
      check("sram_half_data", l_wd[31:16], 16'hbeef);
      xfer(32'h2000_0ffc, 1'b0, HSIZE_WORD, 32'h0);
      check("sram_rd", {err, rd}, {1'b0, SR_DATA});
      xfer(32'h2000_0003, 1'b0, HSIZE_BYTE, 32'h0);
      check("sram_byte_rd", {err, rd}, {1'b0, SR_DATA});
      check("sram_writes", n_sramw, 2);
      xfer(32'h2000_0000, 1'b0, 3'b011, 32'h0);
      check("wide_size_err", err, 1'b1);
   endtask

   task automatic t_ahbp();
      xfer(32'h4008_0010, 1'b1, HSIZE_WORD, 32'h0000_0001);
      check("fc_sel", {err, 32'(n_fc)}, {1'b0, 32'd1});
      xfer(32'h4008_9ffc, 1'b0, HSIZE_WORD, 32'h0);
      check("cr_rd", {err, rd, 32'(n_cr)}, {1'b0, AP_DATA, 32'd1});
      xfer(32'h4008_0000, 1'b0, HSIZE_HALF, 32'h0);
      check("ahbp_narrow_err", {err, 32'(n_fc)}, {1'b1, 32'd1});
      xfer(32'h4008_2000, 1'b0, HSIZE_WORD, 32'h0);
      check("ahbp_gap_err", err, 1'b1);
      xfer(32'h400f_fffc, 1'b0, HSIZE_WORD, 32'h0);
      check("ahbp_top_err", err, 1'b1);
   endtask

   task automatic t_apb();
      pwait = 4'h3;
      xfer(32'h4000_1001, 1'b1, HSIZE_BYTE, 32'h0000_5a00);
      check("apb_byte_err", err, 1'b0);
      check("apb_byte_repl", wd_seen, 32'h5a5a_5a5a);
      check("apb_stall", cyc >= 7, 1'b1);
      pwait = 4'h0;
      xfer(32'h4000_4002, 1'b1, HSIZE_HALF, 32'hbeef_0000);
      check("apb_half_repl", wd_seen, 32'hbeef_beef);
      pwait = 4'h2;
      xfer(32'h4000_4008, 1'b0, HSIZE_WORD, 32'h0);
      check("apb_rd", {err, rd}, {1'b0, 32'hc0de_4008});
      check("apb_rd_addr", {pwrite, paddr}, {1'b0, 32'h4000_4008});
   endtask

   task automatic t_unmapped();
      xfer(32'h6000_0000, 1'b0, HSIZE_WORD, 32'h0);
      check("unmapped_err", {err, 32'(cyc)}, {1'b1, 32'd2});
      xfer(32'hffff_fffc, 1'b1, HSIZE_WORD, 32'h0);
      check("top_addr_err", err, 1'b1);
   endtask

   task automatic t_priority();
      cpu_seen = 1'b0;
      dbg_seen = 1'b0;
      d_trans  = HTRANS_NONSEQ;
      d_addr   = 32'h0000_0100;
      c_trans  = HTRANS_NONSEQ;
      c_addr   = 32'h2000_0010;
      @(posedge sys_clk);
      #1;
      c_trans = HTRANS_IDLE;
      check("cpu_first", {cpu_g, dbg_g}, 2'b10);
      for (int i = 0; i < 20 && dbg_g !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      d_trans = HTRANS_IDLE;
      check("dbg_later", {cpu_g, dbg_g}, 2'b01);
      repeat (4) @(posedge sys_clk);
      #1;
      check("both_granted", {cpu_seen, dbg_seen}, 2'b11);
   endtask

   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial begin
      {sys_clk, c_wr, d_wr, c_trans, d_trans, c_addr, d_addr, hwdata, gates, pwait} = '0;
      {c_size, d_size} = {HSIZE_WORD, HSIZE_WORD};
      {fails, cmp_count, n_flash, n_sramw, n_fc, n_cr} = '0;
      rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_flash();
      t_sram();
      t_ahbp();
      t_apb();
      t_unmapped();
      t_priority();
      test_done();
   end

   // Watchdog against a hung handshake
   initial begin
      #20000;
      fails++;
      test_done();
   end
endmodule
